// file: rtl/irq_ctl_cfg.svh
`ifndef IRQ_CTL_CFG_SVH
`define IRQ_CTL_CFG_SVH
// register byte offsets
`define OFS_PENDING 5'h00
`define OFS_BASIC_MASK 5'h04
`define OFS_EXT_MASK 5'h08
`define OFS_BASIC_LVL 5'h0c
`define OFS_EXT_LVL 5'h10
`define OFS_STATUS 5'h14
// field position and source counts
`define GATE_BIT 7
`define BASIC_SRCS 7
`define EXT_SRCS 9
// reset values
`define RST_MASK8 8'h00
`define RST_MASK9 9'h000
`define RST_PEND 16'h0000
// flags cleared by hardware on vectoring
`define AUTO_CLR 16'h000f
// vector table layout
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define GAP_SRC 4'hd
// call sequence length in clocks
`define CALL_CYC 3'h4
`endif

// file: rtl/irq_pkg.sv
package irq_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } state_type;
endpackage

// file: rtl/irq_vector_rom.sv
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctl_cfg.svh"
module irq_vector_rom (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic [3:0] i_src,
  output logic [15:0] o_vec
);
  logic [15:0] table_mem [16];
  // one slot in the order is reserved, so later sources skip it
  for (genvar g = 0; g < 16; g++) begin : g_tab
    localparam logic [15:0] ORD = (g < `GAP_SRC) ? 16'(g) : 16'(g + 1);
    assign table_mem[g] = `VEC_BASE + ORD * `VEC_STEP;
  end
  // registered read
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_vec <= table_mem[i_src];
    end
  end
endmodule // irq_vector_rom
`default_nettype wire

// file: rtl/two_level_interrupt_controller.sv
// Functional notes
// - source event sets its pending flag
// - pending and enabled raises a request
// - long call issued at instruction boundary
// - return instruction resumes interrupted program
// - flags set even while source disabled
// - each source has own enable bit
// - source enables need global gate set
// - global gate low blocks all sources
// - some flags cleared on vectoring
// - flag left set re-enters after one instruction
// - sixteen sources with own vector and order
// - software set acts like hardware event
// - per source level bit, low or high
// - all levels low after reset
// - high preempts low, high never preempted
// - higher level served first
// - fixed order breaks equal level ties
// - requests sampled and decoded every cycle
// - one detect cycle plus four call cycles
// - one instruction runs after return first
// - equal or higher waits until return
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctl_cfg.svh"
module two_level_interrupt_controller (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire irq_pkg::wb_req_type i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic [15:0] i_src_event,
  input wire logic i_insn_done,
  input wire logic i_reti,
  output logic o_call,
  output logic [15:0] o_vector,
  output logic [1:0] o_active_level
);
  import irq_pkg::*;

  // lowest index wins among equal level requests
  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // register state
  logic [15:0] pending_ff;
  logic [7:0] basic_source_mask_reg;
  logic [8:0] extended_source_mask_reg;
  logic [6:0] basic_level_select_reg;
  logic [8:0] extended_level_select_reg;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // arbitration state
  logic req_valid_ff;
  logic win_hi_ff;
  logic [3:0] win_src_ff;
  logic [1:0] active_ff;
  logic hold_ff;
  logic call_ff;
  logic [15:0] vector_ff;
  state_type state_ff;
  logic [2:0] cnt_ff;
  logic [15:0] rom_vec;

  // bus decode
  wire bus_req = i_wb.cyc & i_wb.stb & ~ack_ff;
  wire bus_wr = bus_req & i_wb.we;
  wire hit_pend = i_wb.adr == `OFS_PENDING;
  wire hit_bmask = i_wb.adr == `OFS_BASIC_MASK;
  wire hit_emask = i_wb.adr == `OFS_EXT_MASK;
  wire hit_blvl = i_wb.adr == `OFS_BASIC_LVL;
  wire hit_elvl = i_wb.adr == `OFS_EXT_LVL;
  wire hit_stat = i_wb.adr == `OFS_STATUS;
  wire [15:0] byte_mask = {{8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};

  wire global_irq_gate = basic_source_mask_reg[`GATE_BIT];

  wire [15:0] src_en = {extended_source_mask_reg,
                        basic_source_mask_reg[`BASIC_SRCS-1:0]};
  wire [15:0] lvl_vec = {extended_level_select_reg, basic_level_select_reg};

  wire [15:0] req_vec = pending_ff & src_en & {16{global_irq_gate}};
  wire [15:0] hi_vec = req_vec & lvl_vec;

  wire any_hi = |hi_vec;
  wire any_req = |req_vec;
  wire [3:0] win_src = any_hi ? first_set(hi_vec) : first_set(req_vec);

  wire allowed = win_hi_ff ? ~active_ff[1] : (active_ff == 2'b00);

  // call only at an instruction boundary
  // blocked while equal or higher runs
  // the first completion after a return is the one extra instruction
  wire take_call = (state_ff == ST_IDLE) & i_insn_done & req_valid_ff & allowed;

  // hardware cleared flags of the winner
  wire [15:0] win_onehot = 16'h0001 << win_src_ff;
  wire [15:0] auto_clr = take_call ? (win_onehot & `AUTO_CLR) : 16'h0000;

  // software writes, ones set and zeros clear
  wire pend_wr = bus_wr & hit_pend;
  wire [15:0] sw_set = pend_wr ? (i_wb.dat[15:0] & byte_mask) : 16'h0000;
  wire [15:0] sw_clr = pend_wr ? (~i_wb.dat[15:0] & byte_mask) : 16'h0000;

  // events set flags, a set beats a same cycle clear
  // enable plays no part in setting
  wire [15:0] nxt_pending = ((pending_ff & ~sw_clr & ~auto_clr) | sw_set) | i_src_event;

  // read mux
  wire [31:0] rd_mux = hit_pend ? {16'h0000, pending_ff} :
                       hit_bmask ? {24'h000000, basic_source_mask_reg} :
                       hit_emask ? {23'h000000, extended_source_mask_reg} :
                       hit_blvl ? {25'h0000000, basic_level_select_reg} :
                       hit_elvl ? {23'h000000, extended_level_select_reg} :
                       hit_stat ? {24'h000000, active_ff, win_hi_ff, req_valid_ff,
                                   win_src_ff} :
                       32'h00000000;

  // bus answer, unmapped reads give zero and still ack
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else if (i_ce) begin
      ack_ff <= bus_req;
      rdat_ff <= bus_req ? rd_mux : rdat_ff;
    end
  end

  // pending flags
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pending_ff <= `RST_PEND;
    end else if (i_ce) begin
      pending_ff <= nxt_pending;
    end
  end

  // mask registers, byte lane 0 for the basic one
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      basic_source_mask_reg <= `RST_MASK8;
      extended_source_mask_reg <= `RST_MASK9;
    end else if (i_ce) begin
      if (bus_wr & hit_bmask & i_wb.sel[0]) begin
        basic_source_mask_reg <= i_wb.dat[7:0];
      end
      if (bus_wr & hit_emask) begin
        if (i_wb.sel[0]) begin
          extended_source_mask_reg[7:0] <= i_wb.dat[7:0];
        end
        if (i_wb.sel[1]) begin
          extended_source_mask_reg[8] <= i_wb.dat[8];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      basic_level_select_reg <= 7'h00;
      extended_level_select_reg <= `RST_MASK9;
    end else if (i_ce) begin
      if (bus_wr & hit_blvl & i_wb.sel[0]) begin
        basic_level_select_reg <= i_wb.dat[6:0];
      end
      if (bus_wr & hit_elvl) begin
        if (i_wb.sel[0]) begin
          extended_level_select_reg[7:0] <= i_wb.dat[7:0];
        end
        if (i_wb.sel[1]) begin
          extended_level_select_reg[8] <= i_wb.dat[8];
        end
      end
    end
  end

  // this is the single detect cycle
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      req_valid_ff <= 1'b0;
      win_hi_ff <= 1'b0;
      win_src_ff <= 4'h0;
    end else if (i_ce) begin
      req_valid_ff <= any_req;
      win_hi_ff <= any_hi;
      win_src_ff <= win_src;
    end
  end

  // vector lookup tracks the detect stage
  irq_vector_rom u_rom (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_src(win_src),
    .o_vec(rom_vec)
  );

  // after a return one instruction must pass
  // hold cleared by the next completion
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      hold_ff <= 1'b0;
    end else if (i_ce) begin
      if (i_reti) begin
        hold_ff <= 1'b1;
      end else if (i_insn_done) begin
        hold_ff <= 1'b0;
      end
    end
  end

  // return drops the topmost running level
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      active_ff <= 2'b00;
    end else if (i_ce) begin
      if (take_call) begin
        active_ff <= active_ff | (win_hi_ff ? 2'b10 : 2'b01);
      end else if (i_reti) begin
        active_ff <= active_ff[1] ? {1'b0, active_ff[0]} : 2'b00;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
    end else if (i_ce) begin
      unique case (state_ff)
        ST_IDLE: begin
          if (take_call) begin
            state_ff <= ST_CALL;
            cnt_ff <= `CALL_CYC - 3'h2;
          end
        end
        ST_CALL: begin
          cnt_ff <= cnt_ff - 3'h1;
          if (cnt_ff == 3'h0) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      call_ff <= 1'b0;
      vector_ff <= 16'h0000;
    end else if (i_ce) begin
      call_ff <= take_call;
      vector_ff <= take_call ? rom_vec : vector_ff;
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;
  assign o_call = call_ff;
  assign o_vector = vector_ff;
  assign o_active_level = active_ff;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_pend_set: assert property (
    i_ce |=> ((pending_ff & $past(i_src_event)) == $past(i_src_event)))
    else $error("event did not set pending flag");
  chk_gate_off: assert property (
    (i_ce && !global_irq_gate) |=> !req_valid_ff)
    else $error("request while global gate low");
  chk_call_edge: assert property (
    $rose(call_ff) |-> $past(i_insn_done) && $past(i_ce))
    else $error("call not at instruction boundary");
  chk_hi_no_preempt: assert property (
    call_ff |-> !$past(active_ff[1]))
    else $error("high level routine preempted");
  chk_hi_first: assert property (
    (i_ce && |hi_vec) |=> win_hi_ff && lvl_vec[win_src_ff] | !$past(i_ce))
    else $error("low level won over high");
  chk_reti_gap: assert property (
    (i_ce && i_reti) |=> !call_ff)
    else $error("call directly after return");
  chk_lvl_reset: assert property (
    $past(i_reset) |-> lvl_vec == 16'h0000)
    else $error("level not low after reset");
  chk_call_len: assert property (
    (take_call && i_ce) ##1 i_ce [*3] |=> state_ff == ST_IDLE)
    else $error("call sequence length wrong");
  chk_sw_set: assert property (
    (i_ce && pend_wr && i_wb.sel[0] && i_wb.dat[0]) |=> pending_ff[0])
    else $error("software set lost");

  // re-entry, auto clear and vector lookup checks
  chk_one_insn: assert property (
    (i_ce && hold_ff && i_insn_done && req_valid_ff && allowed && state_ff == ST_IDLE)
    |=> call_ff)
    else $error("no re-entry after one instruction");
  chk_hold_clear: assert property (
    (i_ce && hold_ff && i_insn_done && !i_reti) |=> !hold_ff)
    else $error("return window not closed");
  chk_auto_clr: assert property (
    (i_ce && take_call && win_src_ff < 4'h4 && !i_src_event[win_src_ff] && !pend_wr)
    |=> !pending_ff[$past(win_src_ff)])
    else $error("auto cleared flag still set");
  chk_vec_lookup: assert property (
    call_ff |-> vector_ff[2:0] == 3'h3)
    else $error("vector off the table grid");

  cov_sw_set: cover property (pend_wr && i_ce);
  cov_call: cover property (take_call && i_ce);
  cov_preempt: cover property (call_ff && active_ff == 2'b11);
  cov_reenter: cover property (i_reti ##[1:20] call_ff);
endmodule // two_level_interrupt_controller
`default_nettype wire

// file: dv/cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural core: completes instructions, takes calls, returns on command
module cpu_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_call,
  input wire logic i_do_ret,
  input wire logic i_slow,
  output logic o_insn_done,
  output logic o_reti
);
  logic [2:0] busy_ff;
  logic phase_ff;
  logic ret_ff;
  // one completion pulse per instruction, never both kinds in one cycle
  always_ff @(posedge i_clk) begin
    o_insn_done <= 1'b0;
    o_reti <= 1'b0;
    if (i_reset) begin
      busy_ff <= 3'h0;
      phase_ff <= 1'b0;
      ret_ff <= 1'b0;
    end else if (i_call) begin
      busy_ff <= 3'h3;
    end else if (busy_ff != 3'h0) begin
      busy_ff <= busy_ff - 3'h1;
    end else begin
      // slow mode: an instruction every other cycle
      phase_ff <= ~phase_ff;
      if (!i_slow || phase_ff) begin
        o_reti <= ret_ff;
        o_insn_done <= ~ret_ff;
        ret_ff <= 1'b0;
      end
    end
    // return is queued until the core is free
    if (i_do_ret && !i_reset) begin
      ret_ff <= 1'b1;
    end
  end
endmodule // cpu_model
`default_nettype wire

// file: dv/test_two_level_interrupt_controller.sv
`timescale 1ns/100ps
`default_nettype none
module test_two_level_interrupt_controller;
  import irq_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  wb_req_type wb_q = '0;
  logic [15:0] ev = 16'h0000;
  logic do_ret = 1'b0;
  logic slow = 1'b0;
  logic ack, call, insn, reti;
  logic [31:0] rdat;
  logic [15:0] vec;
  logic [1:0] lvl;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ins_n = 0;
  always #2 i_clk = ~i_clk;
  two_level_interrupt_controller dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
    .i_wb(wb_q), .o_wb_ack(ack), .o_wb_dat(rdat), .i_src_event(ev), .i_insn_done(insn),
    .i_reti(reti), .o_call(call), .o_vector(vec), .o_active_level(lvl));
  cpu_model cpu (.i_clk(i_clk), .i_reset(i_reset), .i_call(call), .i_do_ret(do_ret),
    .i_slow(slow), .o_insn_done(insn), .o_reti(reti));
  // instructions since last return; hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (reti) ins_n <= 0;
    else if (insn) ins_n <= ins_n + 1;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: held until ack is seen at an edge, then released
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
                    input logic [31:0] exp);
    int n;
    @(posedge i_clk);
    wb_q <= '{1'b1, 1'b1, we, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk(32'(ack), 32'h1);
    if (!we) chk(rdat, exp);
    wb_q <= '0;
  endtask
  // n_exp counts edges from the event edge until the call is seen
  task automatic wait_call(input logic [15:0] v, input logic [1:0] l, input int n_exp);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      ev <= 16'h0000;
      n++;
    end while (call !== 1'b1 && n < 60);
    chk(32'(call), 32'h1);
    chk(32'(vec), 32'(v));
    chk(32'(lvl), 32'(l));
    if (n_exp > 0) chk(n, n_exp);
  endtask
  task automatic no_call(input int k);
    repeat (k) begin
      @(posedge i_clk);
      chk(32'(call), 32'h0);
    end
  endtask
  task automatic do_return();
    @(posedge i_clk);
    do_ret <= 1'b1;
    @(posedge i_clk);
    do_ret <= 1'b0;
  endtask
  function automatic logic [15:0] vec_of(input int s);
    return 16'h0003 + 16'(8 * (s < 13 ? s : s + 1));
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int a = 0; a < 28; a += 4) wb(1'b0, 5'(a), 32'h0, 32'h0);
    $display("reset values test done");
    wb(1'b1, 5'h04, 32'h7f, 32'h0);
    wb(1'b1, 5'h08, 32'h1ff, 32'h0);
    @(posedge i_clk);
    ev <= 16'h0020;
    @(posedge i_clk);
    ev <= 16'h0000;
    no_call(10);
    wb(1'b0, 5'h00, 32'h0, 32'h20);
    wb(1'b1, 5'h04, 32'hdf, 32'h0);
    no_call(10);
    wb(1'b1, 5'h04, 32'hff, 32'h0);
    wait_call(16'h002b, 2'h1, 0);
    do_return();
    wait_call(16'h002b, 2'h1, 0);
    chk(ins_n, 1);
    wb(1'b1, 5'h00, 32'h0, 32'h0);
    do_return();
    no_call(8);
    $display("gating test done");
    for (int s = 0; s < 16; s++) begin
      slow <= s[0];
      wb(1'b1, 5'h00, 32'(1 << s), 32'h0);
      wait_call(vec_of(s), 2'h1, 0);
      wb(1'b0, 5'h00, 32'h0, (s < 4) ? 32'h0 : 32'(1 << s));
      wb(1'b1, 5'h00, 32'h0, 32'h0);
      do_return();
      no_call(8);
    end
    slow <= 1'b0;
    $display("vector test done");
    wb(1'b1, 5'h00, 32'h204, 32'h0);
    wait_call(16'h0013, 2'h1, 0);
    do_return();
    wait_call(16'h004b, 2'h1, 0);
    chk(ins_n, 1);
    wb(1'b1, 5'h00, 32'h0, 32'h0);
    do_return();
    no_call(8);
    $display("order test done");
    wb(1'b1, 5'h10, 32'h4, 32'h0);
    wb(1'b1, 5'h00, 32'h202, 32'h0);
    wait_call(16'h004b, 2'h2, 0);
    no_call(10);
    wb(1'b1, 5'h00, 32'h2, 32'h0);
    do_return();
    wait_call(16'h000b, 2'h1, 0);
    no_call(6);
    @(posedge i_clk);
    ev <= 16'h0200;
    wait_call(16'h004b, 2'h3, 4);
    no_call(10);
    wb(1'b1, 5'h00, 32'h0, 32'h0);
    do_return();
    no_call(8);
    do_return();
    no_call(8);
    chk(32'(lvl), 32'h0);
    $display("level test done");
    final_report();
  end
endmodule // test_two_level_interrupt_controller
`default_nettype wire
